/* rtl/cssq_pkg.sv */
// Constants and types shared by the core stack and interrupt sequencer.
// Functional notes
// - Four operand and result port schemes.
// - Working registers mapped at data addresses 0-31.
// - Top six registers form three pointers.
// - Push byte minus one, call minus two.
// - Pop byte plus one, returns plus two.
// - Stack pointer I/O bytes, reset SRAM end.
// - Undivided CPU clock drives everything.
// - Two-operand ALU op in one cycle.
// - Take needs own and global enable.
// - Lower vector means higher priority.
// - Entry clears global enable, return sets.
// - Vectoring or writing one clears flag.
// - Disabled events stay pending as flags.
// - Level requests only while condition holds.
// - One instruction runs after each return.
// - Status register never saved by hardware.
// - Clear-global acts at once, same cycle.
// - Instruction after set-global runs first.
// - Four cycle entry pushing program counter.
// - Sleeping adds four cycles to entry.
// - Return takes four cycles, pops two.
`default_nettype none
package cssq_pkg;
    localparam int          N_IRQ       = 8;
    localparam logic [5:0]  IO_SP_LO    = 6'h3d;
    localparam logic [5:0]  IO_SP_HI    = 6'h3e;
    localparam logic [15:0] DS_IO_BASE  = 16'h0020;
    localparam logic [15:0] SP_RESET    = 16'h02ff;
    localparam logic [15:0] SP_MASK     = 16'h03ff;
    localparam logic [4:0]  REG_PTR_LO  = 5'h1a;
    localparam logic [15:0] VEC_STRIDE  = 16'h0002;
    localparam logic [7:0]  LEVEL_MASK  = 8'hc0;
    localparam logic [3:0]  ENTRY_CYC   = 4'h4;
    localparam logic [3:0]  SLEEP_EXTRA = 4'h4;
    localparam logic [3:0]  EXIT_CYC    = 4'h4;

    typedef enum logic [2:0] {
        STK_NONE, STK_PUSH, STK_POP, STK_CALL, STK_RET, STK_IRQ_EXIT
    } cssq_stk_op_t;

    typedef enum logic [1:0] {
        PTR_PLAIN, PTR_DISP, PTR_POSTINC, PTR_PREDEC
    } cssq_ptr_mode_t;

    typedef enum logic [1:0] {
        SEQ_RUN, SEQ_ENTRY, SEQ_EXIT
    } cssq_seq_t;

    typedef struct packed {
        logic        en;
        logic        wide;
        logic [4:0]  addr;
        logic [15:0] data;
    } cssq_rf_wr_t;

    typedef struct packed {
        logic           go;
        logic [1:0]     sel;
        cssq_ptr_mode_t mode;
        logic [5:0]     disp;
    } cssq_ptr_req_t;

    typedef struct packed {
        logic [31:0][7:0]   regs;
        logic [15:0]        sp;
        logic               gie;
        logic [N_IRQ-1:0]   flags;
        cssq_seq_t          st;
        logic [3:0]         cnt;
        logic [2:0]         vec;
        logic [15:0]        ret_pc;
        logic               pc_load;
        logic [15:0]        pc_val;
    } cssq_state_t;
endpackage
`default_nettype wire

/* rtl/cssq_core.sv */
// Register file, pointers, stack pointer and interrupt entry and return sequencer.
`default_nettype none
module cssq_core (
    input  wire logic                          REF_CLK_IN,
    input  wire logic                          RST_IN,
    input  wire logic [4:0]                    RF_RD_A_IN,
    input  wire logic [4:0]                    RF_RD_B_IN,
    output logic [7:0]                         RF_A_OUT,
    output logic [7:0]                         RF_B_OUT,
    output logic [15:0]                        RF_PAIR_OUT,
    input  wire cssq_pkg::cssq_rf_wr_t         RF_WR_IN,
    input  wire logic [15:0]                   DS_ADDR_IN,
    input  wire logic                          DS_WE_IN,
    input  wire logic [7:0]                    DS_WD_IN,
    output logic [7:0]                         DS_RD_OUT,
    output logic                               DS_HIT_OUT,
    input  wire logic [5:0]                    IO_ADDR_IN,
    input  wire logic                          IO_WE_IN,
    input  wire logic [7:0]                    IO_WD_IN,
    output logic [7:0]                         IO_RD_OUT,
    input  wire cssq_pkg::cssq_ptr_req_t       PTR_REQ_IN,
    output logic [15:0]                        PTR_ADDR_OUT,
    input  wire cssq_pkg::cssq_stk_op_t        STK_OP_IN,
    output logic [15:0]                        STK_ADDR_OUT,
    output logic                               STK_WE_OUT,
    output logic [7:0]                         STK_WD_OUT,
    output logic                               STK_RE_OUT,
    input  wire logic [7:0]                    STK_RD_IN,
    output logic [15:0]                        SP_OUT,
    input  wire logic [cssq_pkg::N_IRQ-1:0]    IRQ_COND_IN,
    input  wire logic [cssq_pkg::N_IRQ-1:0]    IRQ_EN_IN,
    input  wire logic [cssq_pkg::N_IRQ-1:0]    FLAG_CLR_IN,
    output logic [cssq_pkg::N_IRQ-1:0]         FLAGS_OUT,
    input  wire logic                          INSN_DONE_IN,
    input  wire logic                          SEI_IN,
    input  wire logic                          CLI_IN,
    input  wire logic                          GIE_WR_IN,
    input  wire logic                          GIE_WD_IN,
    input  wire logic                          SLEEP_IN,
    input  wire logic [15:0]                   PC_IN,
    output logic                               GIE_OUT,
    output logic                               IRQ_TAKE_OUT,
    output logic                               BUSY_OUT,
    output logic                               PC_LOAD_OUT,
    output logic [15:0]                        PC_VAL_OUT
);
    cssq_pkg::cssq_state_t         r_reg;
    cssq_pkg::cssq_state_t         r_next;
    logic [cssq_pkg::N_IRQ-1:0]    req;
    logic [2:0]                    pick;
    logic                          any_req;
    logic                          take;
    logic                          ds_reg;
    logic                          sp_wr_lo;
    logic                          sp_wr_hi;
    logic [4:0]                    pb;
    logic [15:0]                   ptr_cur;
    logic [15:0]                   ptr_new;
    logic [15:0]                   ds_sp_lo;
    logic [15:0]                   ds_sp_hi;
    logic                          stk_pop;

    // Read paths are plain muxes on the flops so an ALU can read, compute and write back
    // within one clock.
    assign RF_A_OUT    = r_reg.regs[RF_RD_A_IN];
    assign RF_B_OUT    = r_reg.regs[RF_RD_B_IN];
    assign RF_PAIR_OUT = {r_reg.regs[{RF_RD_A_IN[4:1], 1'b1}],
                          r_reg.regs[{RF_RD_A_IN[4:1], 1'b0}]};

    assign ds_reg   = (DS_ADDR_IN < cssq_pkg::DS_IO_BASE);
    assign ds_sp_lo = cssq_pkg::DS_IO_BASE + {10'h000, cssq_pkg::IO_SP_LO};
    assign ds_sp_hi = cssq_pkg::DS_IO_BASE + {10'h000, cssq_pkg::IO_SP_HI};
    assign DS_HIT_OUT = ds_reg || DS_ADDR_IN == ds_sp_lo || DS_ADDR_IN == ds_sp_hi;

    always_comb begin
        if (ds_reg) begin
            DS_RD_OUT = r_reg.regs[DS_ADDR_IN[4:0]];
        end else if (DS_ADDR_IN == ds_sp_lo) begin
            DS_RD_OUT = r_reg.sp[7:0];
        end else if (DS_ADDR_IN == ds_sp_hi) begin
            DS_RD_OUT = r_reg.sp[15:8];
        end else begin
            DS_RD_OUT = 8'h00;
        end
    end

    always_comb begin
        if (IO_ADDR_IN == cssq_pkg::IO_SP_LO) begin
            IO_RD_OUT = r_reg.sp[7:0];
        end else if (IO_ADDR_IN == cssq_pkg::IO_SP_HI) begin
            IO_RD_OUT = r_reg.sp[15:8];
        end else begin
            IO_RD_OUT = 8'h00;
        end
    end

    assign sp_wr_lo = (IO_WE_IN && IO_ADDR_IN == cssq_pkg::IO_SP_LO)
                   || (DS_WE_IN && DS_ADDR_IN == ds_sp_lo);
    assign sp_wr_hi = (IO_WE_IN && IO_ADDR_IN == cssq_pkg::IO_SP_HI)
                   || (DS_WE_IN && DS_ADDR_IN == ds_sp_hi);

    // Pointer pairs start at the low byte of the first of the top six registers.
    assign pb      = cssq_pkg::REG_PTR_LO + {2'b00, PTR_REQ_IN.sel, 1'b0};
    assign ptr_cur = {r_reg.regs[pb | 5'h01], r_reg.regs[pb]};

    always_comb begin
        case (PTR_REQ_IN.mode)
            cssq_pkg::PTR_DISP:    PTR_ADDR_OUT = ptr_cur + {10'h000, PTR_REQ_IN.disp};
            cssq_pkg::PTR_PREDEC:  PTR_ADDR_OUT = ptr_cur - 16'h0001;
            default:               PTR_ADDR_OUT = ptr_cur;
        endcase
        case (PTR_REQ_IN.mode)
            cssq_pkg::PTR_POSTINC: ptr_new = ptr_cur + 16'h0001;
            cssq_pkg::PTR_PREDEC:  ptr_new = ptr_cur - 16'h0001;
            default:               ptr_new = ptr_cur;
        endcase
    end

    // Flag-type sources request from the flag, level-type ones only from the live condition.
    assign req = ((r_reg.flags & ~cssq_pkg::LEVEL_MASK)
               | (IRQ_COND_IN & cssq_pkg::LEVEL_MASK)) & IRQ_EN_IN;

    always_comb begin
        pick    = 3'h0;
        any_req = 1'b0;
        for (int i = cssq_pkg::N_IRQ - 1; i >= 0; i--) begin
            if (req[i]) begin
                pick    = i[2:0];
                any_req = 1'b1;
            end
        end
    end

    // The enable is sampled from the flop, so the instruction after a set-global completes
    // before a take, and a clear in the same cycle blocks the take.
    assign take = r_reg.st == cssq_pkg::SEQ_RUN && INSN_DONE_IN && any_req
               && r_reg.gie && !CLI_IN && !(GIE_WR_IN && !GIE_WD_IN)
               && STK_OP_IN != cssq_pkg::STK_IRQ_EXIT;

    assign stk_pop = STK_OP_IN == cssq_pkg::STK_POP || STK_OP_IN == cssq_pkg::STK_RET;

    always_comb begin
        r_next         = r_reg;
        r_next.pc_load = 1'b0;
        if (RF_WR_IN.en) begin
            if (RF_WR_IN.wide) begin
                r_next.regs[{RF_WR_IN.addr[4:1], 1'b0}] = RF_WR_IN.data[7:0];
                r_next.regs[{RF_WR_IN.addr[4:1], 1'b1}] = RF_WR_IN.data[15:8];
            end else begin
                r_next.regs[RF_WR_IN.addr] = RF_WR_IN.data[7:0];
            end
        end
        if (DS_WE_IN && ds_reg) begin
            r_next.regs[DS_ADDR_IN[4:0]] = DS_WD_IN;
        end
        if (PTR_REQ_IN.go) begin
            r_next.regs[pb]         = ptr_new[7:0];
            r_next.regs[pb | 5'h01] = ptr_new[15:8];
        end
        if (sp_wr_lo) begin
            r_next.sp[7:0] = sp_wr_lo ? (IO_WE_IN ? IO_WD_IN : DS_WD_IN) : 8'h00;
        end
        if (sp_wr_hi) begin
            r_next.sp[15:8] = IO_WE_IN ? IO_WD_IN : DS_WD_IN;
        end
        // Hardware sets win over the software write-one clear.
        r_next.flags = (r_reg.flags & ~FLAG_CLR_IN)
                     | (IRQ_COND_IN & ~cssq_pkg::LEVEL_MASK);
        if (SEI_IN) begin
            r_next.gie = 1'b1;
        end
        if (CLI_IN) begin
            r_next.gie = 1'b0;
        end
        if (GIE_WR_IN) begin
            r_next.gie = GIE_WD_IN;
        end
        // Only the enable bit is touched here; the other status flags are never stacked.
        case (r_reg.st)
            cssq_pkg::SEQ_RUN: begin
                case (STK_OP_IN)
                    cssq_pkg::STK_PUSH: r_next.sp = r_next.sp - 16'h0001;
                    cssq_pkg::STK_CALL: r_next.sp = r_next.sp - 16'h0002;
                    cssq_pkg::STK_POP:  r_next.sp = r_next.sp + 16'h0001;
                    cssq_pkg::STK_RET:  r_next.sp = r_next.sp + 16'h0002;
                    default: ;
                endcase
                if (STK_OP_IN == cssq_pkg::STK_IRQ_EXIT) begin
                    r_next.st  = cssq_pkg::SEQ_EXIT;
                    r_next.cnt = cssq_pkg::EXIT_CYC - 4'h1;
                end else if (take) begin
                    r_next.st    = cssq_pkg::SEQ_ENTRY;
                    r_next.cnt   = cssq_pkg::ENTRY_CYC - 4'h1
                                 + (SLEEP_IN ? cssq_pkg::SLEEP_EXTRA : 4'h0);
                    r_next.vec   = pick;
                    r_next.ret_pc = PC_IN;
                    r_next.gie   = 1'b0;
                    r_next.flags[pick] = IRQ_COND_IN[pick] & ~cssq_pkg::LEVEL_MASK[pick];
                end
            end
            cssq_pkg::SEQ_ENTRY: begin
                r_next.cnt = r_reg.cnt - 4'h1;
                if (r_reg.cnt == 4'h3 || r_reg.cnt == 4'h2) begin
                    r_next.sp = r_next.sp - 16'h0001;
                end
                if (r_reg.cnt == 4'h1) begin
                    r_next.pc_load = 1'b1;
                    r_next.pc_val  = ({13'h0000, r_reg.vec} + 16'h0001) * cssq_pkg::VEC_STRIDE;
                end
                if (r_reg.cnt == 4'h0) begin
                    r_next.st = cssq_pkg::SEQ_RUN;
                end
            end
            cssq_pkg::SEQ_EXIT: begin
                r_next.cnt = r_reg.cnt - 4'h1;
                if (r_reg.cnt == 4'h3 || r_reg.cnt == 4'h2) begin
                    r_next.sp = r_next.sp + 16'h0001;
                end
                if (r_reg.cnt == 4'h2) begin
                    r_next.ret_pc[15:8] = STK_RD_IN;
                end
                if (r_reg.cnt == 4'h1) begin
                    r_next.pc_load = 1'b1;
                    r_next.pc_val  = {r_reg.ret_pc[15:8], STK_RD_IN};
                    r_next.gie     = 1'b1;
                end
                if (r_reg.cnt == 4'h0) begin
                    // No take is possible until the next instruction boundary.
                    r_next.st = cssq_pkg::SEQ_RUN;
                end
            end
            default: begin
                r_next.st = cssq_pkg::SEQ_RUN;
            end
        endcase
        r_next.sp = r_next.sp & cssq_pkg::SP_MASK;
    end

    // Runs straight off the chip clock with no divider.
    always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            r_reg         <= '0;
            r_reg.sp      <= cssq_pkg::SP_RESET;
            r_reg.st      <= cssq_pkg::SEQ_RUN;
        end else begin
            r_reg <= r_next;
        end
    end

    assign SP_OUT       = r_reg.sp;
    assign GIE_OUT      = r_reg.gie;
    assign FLAGS_OUT    = r_reg.flags;
    assign PC_LOAD_OUT  = r_reg.pc_load;
    assign PC_VAL_OUT   = r_reg.pc_val;
    assign IRQ_TAKE_OUT = take;
    assign BUSY_OUT     = r_reg.st != cssq_pkg::SEQ_RUN;

    // Entry pushes the low byte first so the high byte ends on top for the return.
    assign STK_WE_OUT   = r_reg.st == cssq_pkg::SEQ_ENTRY
                       && (r_reg.cnt == 4'h3 || r_reg.cnt == 4'h2);
    assign STK_WD_OUT   = r_reg.cnt == 4'h3 ? r_reg.ret_pc[7:0] : r_reg.ret_pc[15:8];
    assign STK_RE_OUT   = r_reg.st == cssq_pkg::SEQ_EXIT
                       && (r_reg.cnt == 4'h3 || r_reg.cnt == 4'h2);
    assign STK_ADDR_OUT = (r_reg.st == cssq_pkg::SEQ_EXIT
                       || (r_reg.st == cssq_pkg::SEQ_RUN && stk_pop))
                       ? r_reg.sp + 16'h0001 : r_reg.sp;
endmodule
`default_nettype wire

/* bench/cssq_mem_model.sv */
// Behavioural data memory that answers the stack traffic of the core.
`default_nettype none
module cssq_mem_model (
    input  wire logic        clk_in,
    input  wire logic [15:0] addr_in,
    input  wire logic        we_in,
    input  wire logic [7:0]  wd_in,
    input  wire logic        re_in,
    output logic [7:0]       rd_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:1023];
    initial rd_out = 8'h00;
    // Read data is valid only the cycle after a read, so a late capture sees junk.
    always @(posedge clk_in) begin
        if (we_in) begin
            mem[addr_in[9:0]] <= wd_in;
        end
        rd_out <= re_in ? mem[addr_in[9:0]] : ~rd_out;
    end
endmodule
`default_nettype wire

/* bench/cssq_core_props.sv */
// Concurrent checks on the ports of the core stack and interrupt sequencer.
`default_nettype none
module cssq_core_props (
    input wire logic                   REF_CLK_IN,
    input wire logic                   RST_IN,
    input wire logic                   IO_WE_IN,
    input wire logic                   DS_WE_IN,
    input wire cssq_pkg::cssq_stk_op_t STK_OP_IN,
    input wire logic                   STK_WE_OUT,
    input wire logic [7:0]             STK_WD_OUT,
    input wire logic [15:0]            SP_OUT,
    input wire logic [15:0]            PC_IN,
    input wire logic                   INSN_DONE_IN,
    input wire logic                   CLI_IN,
    input wire logic                   SLEEP_IN,
    input wire logic                   GIE_OUT,
    input wire logic                   IRQ_TAKE_OUT,
    input wire logic                   BUSY_OUT,
    input wire logic                   PC_LOAD_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    logic quiet;
    // Stack arithmetic is judged only when no register write can land on the pointer.
    assign quiet = !BUSY_OUT && !IO_WE_IN && !DS_WE_IN && !IRQ_TAKE_OUT;
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);
    sequence s_push_pc;
        STK_WE_OUT && (STK_WD_OUT == $past(PC_IN[7:0])) ##1
        STK_WE_OUT && (STK_WD_OUT == $past(PC_IN[15:8], 2));
    endsequence
    property p_push;
        quiet && STK_OP_IN == cssq_pkg::STK_PUSH |=>
        SP_OUT == (($past(SP_OUT) - 16'h0001) & cssq_pkg::SP_MASK);
    endproperty
    property p_call;
        quiet && STK_OP_IN == cssq_pkg::STK_CALL |=>
        SP_OUT == (($past(SP_OUT) - 16'h0002) & cssq_pkg::SP_MASK);
    endproperty
    property p_pop;
        quiet && STK_OP_IN == cssq_pkg::STK_POP |=>
        SP_OUT == (($past(SP_OUT) + 16'h0001) & cssq_pkg::SP_MASK);
    endproperty
    property p_ret;
        quiet && STK_OP_IN == cssq_pkg::STK_RET |=>
        SP_OUT == (($past(SP_OUT) + 16'h0002) & cssq_pkg::SP_MASK);
    endproperty
    property p_take;
        IRQ_TAKE_OUT |-> GIE_OUT && INSN_DONE_IN && !CLI_IN;
    endproperty
    property p_entry;
        IRQ_TAKE_OUT && !SLEEP_IN |=> !GIE_OUT ##0 s_push_pc ##2 PC_LOAD_OUT;
    endproperty
    property p_sleep;
        IRQ_TAKE_OUT && SLEEP_IN |-> ##8 PC_LOAD_OUT;
    endproperty
    property p_exit;
        quiet && STK_OP_IN == cssq_pkg::STK_IRQ_EXIT |-> ##4 PC_LOAD_OUT ##1
        GIE_OUT && SP_OUT == $past(SP_OUT, 5) + 16'h0002;
    endproperty
    property p_after_ret;
        PC_LOAD_OUT |=> !IRQ_TAKE_OUT;
    endproperty
    property p_sp_width;
        SP_OUT[15:10] == 6'h00;
    endproperty
    a_push: assert property (p_push) else $error("push did not lower sp by one");
    a_call: assert property (p_call) else $error("call did not lower sp by two");
    a_pop: assert property (p_pop) else $error("pop did not raise sp by one");
    a_ret: assert property (p_ret) else $error("ret did not raise sp by two");
    a_take: assert property (p_take) else $error("take without enables");
    a_entry: assert property (p_entry) else $error("bad entry sequence");
    a_sleep: assert property (p_sleep) else $error("bad sleep entry time");
    a_exit: assert property (p_exit) else $error("bad return sequence");
    a_after_ret: assert property (p_after_ret) else $error("take right after load");
    a_sp_width: assert property (p_sp_width) else $error("upper sp bits set");
endmodule
bind cssq_core cssq_core_props u_props (.REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN),
    .IO_WE_IN(IO_WE_IN), .DS_WE_IN(DS_WE_IN), .STK_OP_IN(STK_OP_IN),
    .STK_WE_OUT(STK_WE_OUT), .STK_WD_OUT(STK_WD_OUT), .SP_OUT(SP_OUT), .PC_IN(PC_IN),
    .INSN_DONE_IN(INSN_DONE_IN), .CLI_IN(CLI_IN), .SLEEP_IN(SLEEP_IN), .GIE_OUT(GIE_OUT),
    .IRQ_TAKE_OUT(IRQ_TAKE_OUT), .BUSY_OUT(BUSY_OUT), .PC_LOAD_OUT(PC_LOAD_OUT));
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the core stack and interrupt sequencer.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // Starting the clock low at declaration keeps time zero free of a false falling edge.
    logic                   clk = 1'b0;
    logic                   rst, ds_we, ds_hit, io_we, stk_we, stk_re, take, busy;
    logic                   done, sei, cli, sleep, gie, pc_load, gie_wr, gie_wd;
    logic [4:0]             rd_a, rd_b;
    logic [5:0]             io_addr;
    logic [7:0]             rf_a, rf_b, ds_wd, ds_rd, io_wd, io_rd, stk_wd, stk_rd;
    logic [7:0]             irq_cond, irq_en, flag_clr, flags;
    logic [15:0]            rf_pair, ds_addr, ptr_addr, stk_addr, sp, pc, pc_val, e;
    cssq_pkg::cssq_rf_wr_t  rf_wr;
    cssq_pkg::cssq_ptr_req_t ptr;
    cssq_pkg::cssq_stk_op_t stk_op;
    cssq_pkg::cssq_stk_op_t ops [4] = '{cssq_pkg::STK_PUSH, cssq_pkg::STK_CALL,
                                        cssq_pkg::STK_POP, cssq_pkg::STK_RET};
    logic [15:0]            dlt [4] = '{16'hffff, 16'hfffe, 16'h0001, 16'h0002};
    int                     miscompares = 0;
    int                     n_tests = 0;
    cssq_core dut (.REF_CLK_IN(clk), .RST_IN(rst), .RF_RD_A_IN(rd_a), .RF_RD_B_IN(rd_b),
        .RF_A_OUT(rf_a), .RF_B_OUT(rf_b), .RF_PAIR_OUT(rf_pair), .RF_WR_IN(rf_wr),
        .DS_ADDR_IN(ds_addr), .DS_WE_IN(ds_we), .DS_WD_IN(ds_wd), .DS_RD_OUT(ds_rd),
        .DS_HIT_OUT(ds_hit), .IO_ADDR_IN(io_addr), .IO_WE_IN(io_we), .IO_WD_IN(io_wd),
        .IO_RD_OUT(io_rd), .PTR_REQ_IN(ptr), .PTR_ADDR_OUT(ptr_addr), .STK_OP_IN(stk_op),
        .STK_ADDR_OUT(stk_addr), .STK_WE_OUT(stk_we), .STK_WD_OUT(stk_wd),
        .STK_RE_OUT(stk_re), .STK_RD_IN(stk_rd), .SP_OUT(sp), .IRQ_COND_IN(irq_cond),
        .IRQ_EN_IN(irq_en), .FLAG_CLR_IN(flag_clr), .FLAGS_OUT(flags), .INSN_DONE_IN(done),
        .SEI_IN(sei), .CLI_IN(cli), .GIE_WR_IN(gie_wr), .GIE_WD_IN(gie_wd), .SLEEP_IN(sleep),
        .PC_IN(pc), .GIE_OUT(gie), .IRQ_TAKE_OUT(take), .BUSY_OUT(busy),
        .PC_LOAD_OUT(pc_load), .PC_VAL_OUT(pc_val));
    cssq_mem_model u_mem (.clk_in(clk), .addr_in(stk_addr), .we_in(stk_we), .wd_in(stk_wd),
        .re_in(stk_re), .rd_out(stk_rd));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic stk(input cssq_pkg::cssq_stk_op_t op);
        stk_op = op;
        cyc(1);
        stk_op = cssq_pkg::STK_NONE;
    endtask
    task automatic pulse_cond(input logic [7:0] c, input logic s);
        irq_cond = c;
        cyc(1);
        irq_cond = 8'h00;
        sei = s;
        cyc(1);
        sei = 1'b0;
        cyc(1);
    endtask
    task automatic wait_load(input int lat);
        int n;
        n = 0;
        while (pc_load !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        chk("latency", lat[15:0], n[15:0]);
    endtask
    task automatic take_irq(input int lat, input logic [15:0] vec);
        done = 1'b1;
        #1 chk("take", 16'h0001, {15'h0, take});
        cyc(1);
        done = 1'b0;
        chk("busy", 16'h0001, {15'h0, busy});
        wait_load(lat);
        chk("vector", vec, pc_val);
        cyc(1);
        chk("gie_entry", 16'h0000, {15'h0, gie});
    endtask
    task automatic stop_test;
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        forever #2 clk = ~clk;
    end
    // A hung sequence would otherwise stall the run silently.
    initial begin
        #4000;
        miscompares++;
        stop_test();
    end
    initial begin
        {rst, ds_we, io_we, done, sei, cli, sleep, gie_wr, gie_wd} = 9'h100;
        {rd_a, rd_b, io_addr, ds_addr, ds_wd, io_wd, irq_cond, flag_clr} = '0;
        {rf_wr, ptr, irq_en, pc} = {34'h0, 8'hff, 16'h0456};
        stk_op = cssq_pkg::STK_NONE;
        cyc(8);
        rst = 1'b0;
        chk("sp_reset", cssq_pkg::SP_RESET, sp);
        chk("flags_reset", 16'h0000, {8'h00, flags});
        io_addr = cssq_pkg::IO_SP_HI;
        #1 chk("io_hi", {8'h00, cssq_pkg::SP_RESET[15:8]}, {8'h00, io_rd});
        cyc(1);
        io_addr = 6'h10;
        #1 chk("io_unmapped", 16'h0000, {8'h00, io_rd});
        cyc(1);
        io_addr = cssq_pkg::IO_SP_LO;
        io_wd = 8'h80;
        io_we = 1'b1;
        cyc(1);
        io_we = 1'b0;
        chk("sp_write", 16'h0280, sp);
        ds_addr = cssq_pkg::DS_IO_BASE + 16'h003d;
        #1 chk("ds_sp_lo", 16'h0080, {8'h00, ds_rd});
        cyc(1);
        rf_wr = '{1'b1, 1'b0, 5'h05, 16'h00a5};
        cyc(1);
        rf_wr = '{1'b1, 1'b1, 5'h1a, 16'h1234};
        cyc(1);
        rf_wr = '{1'b1, 1'b1, 5'h1e, 16'h0100};
        cyc(1);
        rf_wr = '0;
        rd_a = 5'h05;
        rd_b = 5'h1b;
        #1 chk("rf_ab", 16'ha512, {rf_a, rf_b});
        cyc(1);
        rd_a = 5'h1a;
        #1 chk("rf_pair", 16'h1234, rf_pair);
        cyc(1);
        ds_addr = 16'h001a;
        #1 chk("ds_reg", 16'h0134, {7'h00, ds_hit, ds_rd});
        cyc(1);
        ds_addr = 16'h0003;
        ds_wd = 8'h77;
        ds_we = 1'b1;
        cyc(1);
        ds_we = 1'b0;
        rd_b = 5'h03;
        #1 chk("ds_to_reg", 16'h0077, {8'h00, rf_b});
        cyc(1);
        ptr = '{1'b1, 2'h0, cssq_pkg::PTR_POSTINC, 6'h00};
        #1 chk("ptr_inc_addr", 16'h1234, ptr_addr);
        cyc(1);
        ptr = '{1'b1, 2'h0, cssq_pkg::PTR_PREDEC, 6'h00};
        #1 chk("ptr_dec_addr", 16'h1234, ptr_addr);
        cyc(1);
        ptr = '{1'b0, 2'h2, cssq_pkg::PTR_DISP, 6'h3f};
        #1 chk("ptr_disp", 16'h013f, ptr_addr);
        chk("ptr_back", 16'h1234, rf_pair);
        cyc(1);
        e = sp;
        for (int i = 0; i < 4; i++) begin
            stk(ops[i]);
            e = e + dlt[i];
            chk("sp_op", e, sp);
            cyc(1);
        end
        pulse_cond(8'h43, 1'b0);
        chk("pending", 16'h0003, {8'h00, flags});
        sei = 1'b1;
        done = 1'b1;
        #1 chk("take_at_sei", 16'h0000, {15'h0, take});
        cyc(1);
        sei = 1'b0;
        take_irq(int'(cssq_pkg::ENTRY_CYC) - 1, 16'h0002);
        chk("flag_vectored", 16'h0002, {8'h00, flags});
        chk("sp_entry", 16'h027e, sp);
        chk("pushed_lo", 16'h0056, {8'h00, u_mem.mem[10'h280]});
        stk(cssq_pkg::STK_IRQ_EXIT);
        wait_load(int'(cssq_pkg::EXIT_CYC) - 1);
        chk("ret_pc", 16'h0456, pc_val);
        cyc(1);
        chk("ret_state", 16'h0280, sp);
        chk("ret_gie", 16'h0001, {15'h0, gie});
        // The interrupted program gets its one instruction before the next boundary.
        cyc(1);
        take_irq(int'(cssq_pkg::ENTRY_CYC) - 1, 16'h0004);
        pulse_cond(8'h04, 1'b1);
        done = 1'b1;
        cli = 1'b1;
        #1 chk("take_at_cli", 16'h0000, {15'h0, take});
        cyc(1);
        {done, cli} = 2'b00;
        flag_clr = 8'h04;
        cyc(1);
        flag_clr = 8'h00;
        chk("flag_w1c", 16'h0000, {8'h00, flags});
        pulse_cond(8'h08, 1'b0);
        {gie_wr, gie_wd} = 2'b11;
        cyc(1);
        gie_wr = 1'b0;
        chk("gie_write", 16'h0001, {15'h0, gie});
        sleep = 1'b1;
        take_irq(int'(cssq_pkg::ENTRY_CYC + cssq_pkg::SLEEP_EXTRA) - 1, 16'h0008);
        sleep = 1'b0;
        stop_test();
    end
endmodule
`default_nettype wire
